// [src/itcr_pkg.sv]
// Purpose: Shared constants for the channel result and configuration register bank.
// Assumes: Byte-wide registers at the printed offsets, 200 MHz mclk.
// Notes:   Scan periods are derived from the clock rate and the sample rates.
package itcr_pkg;
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam logic [7:0]  OFS_CH2_LOW       = 8'h06;
  localparam logic [7:0]  OFS_CH2_HIGH      = 8'h07;
  localparam logic [7:0]  OFS_CH3_LOW       = 8'h08;
  localparam logic [7:0]  OFS_CH3_HIGH      = 8'h09;
  localparam logic [7:0]  OFS_RESET_CTRL    = 8'h0A;
  localparam logic [7:0]  OFS_CH_ENABLE     = 8'h0C;
  localparam logic [7:0]  OFS_SCAN_RATE     = 8'h0D;
  localparam int          BIT_FULL_RESET    = 4;
  localparam int          BIT_CONFIG_HOLD   = 0;
  localparam int          BIT_FAST_SCAN     = 3;
  localparam int          BIT_CONT_SCAN     = 2;
  localparam logic [7:0]  RST_RESULT        = 8'h00;
  localparam logic [7:0]  RST_RESET_CTRL    = 8'h00;
  localparam logic [7:0]  RST_CH_ENABLE     = 8'h1F;
  localparam logic [3:0]  RST_SCAN_RATE     = 4'h1;
  localparam logic [7:0]  MASK_RESET_CTRL   = 8'h11;
  localparam logic [7:0]  MASK_SCAN_RATE    = 8'h0F;
  localparam logic [7:0]  MASK_RESULT_HIGH  = 8'h0F;
  localparam int unsigned FAST_SCAN_SPS     = 160;
  localparam int unsigned FAST_PERIOD_CYC   = CLK_HZ / FAST_SCAN_SPS;
  localparam int unsigned RECOVERY_TIME_NS  = 1000;
  localparam int unsigned CLK_PERIOD_NS     = 5;
  localparam int unsigned RECOVERY_CYC      = (RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SCAN_CNT_W        = 25;
  localparam int          RECOV_CNT_W       = 8;
endpackage : itcr_pkg

// [src/itcr_regs.sv]
// Purpose: Result readback, device reset/hold control, channel enables and normal-power scan timing.
// Assumes: Register port is driven by the serial interface engine on mclk; core inputs are on mclk.
// Notes:   All outputs are registered; the scan tick is a one-cycle enable pulse per scan, held high on every cycle of continuous scan.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Low register holds result bits 7..0.
// - High register: bits 11..8, upper nibble zero.
// - Full reset bit restores all registers.
// - No operation until chip ready is set.
// - Hold bit stops conversions, keeps configuration.
// - Enable bits switch channels 0..3, default on.
// - Low-power bits need matching normal enable.
// - Rate code selects 80/40/20/10 SPS.
// - Fast bit gives 160 SPS over rate.
// - Continuous bit overrides rate and fast.
// - Continuous ignored in low power; fixed increment.
module itcr_regs
  import itcr_pkg::*;
#(
  parameter int unsigned FAST_PERIOD = FAST_PERIOD_CYC
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  output var  logic        reg_rvalid,
  input  wire logic [11:0] ch2_button_result,
  input  wire logic [11:0] ch3_button_result,
  input  wire logic        result_valid,
  input  wire logic        lowpower_mode,
  input  wire logic        lp_scan_tick,
  output var  logic        chip_ready,
  output var  logic        conv_enable,
  output var  logic [3:0]  active_channels,
  output var  logic        scan_tick,
  output var  logic        continuous_active,
  output var  logic        fixed_base_increment
);

  typedef struct packed {
    logic                   hold;
    logic [7:0]             ch_enable;
    logic [3:0]             scan_cfg;
    logic [11:0]            res2;
    logic [11:0]            res3;
    logic [7:0]             rdata;
    logic                   rvalid;
    logic [RECOV_CNT_W-1:0] recov_cnt;
    logic                   ready;
    logic [SCAN_CNT_W-1:0]  scan_cnt;
    logic                   tick;
    logic                   conv;
    logic [3:0]             active;
    logic                   cont;
  } itcr_state_t;

  localparam itcr_state_t ITCR_RESET = '{
    hold:      RST_RESET_CTRL[BIT_CONFIG_HOLD],
    ch_enable: RST_CH_ENABLE,
    scan_cfg:  RST_SCAN_RATE,
    res2:      {RST_RESULT[3:0], RST_RESULT},
    res3:      {RST_RESULT[3:0], RST_RESULT},
    rdata:     8'h00,
    rvalid:    1'b0,
    recov_cnt: RECOV_CNT_W'(RECOVERY_CYC),
    ready:     1'b0,
    scan_cnt:  '0,
    tick:      1'b0,
    conv:      1'b0,
    active:    4'h0,
    cont:      1'b0
  };

  // Period of one normal-power scan in mclk cycles for a given rate setting.
  function automatic logic [SCAN_CNT_W-1:0] itcr_period(input logic [3:0] cfg);
    logic [SCAN_CNT_W-1:0] base;
    base = SCAN_CNT_W'(FAST_PERIOD);
    if (cfg[BIT_FAST_SCAN]) begin
      itcr_period = base;
    end else begin
      itcr_period = base << (3'd1 + {1'b0, cfg[1:0]});
    end
  endfunction : itcr_period

  itcr_state_t cur;
  itcr_state_t next_cur;

  logic                  run_ok;
  logic                  cont_ok;
  logic [SCAN_CNT_W-1:0] period;

  always_comb begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    next_cur.tick = 1'b0;
    if (cur.ready && cur.recov_cnt == '0) begin
      next_cur.ready = 1'b1;
    end
    if (!cur.ready) begin
      if (cur.recov_cnt == '0) begin
        next_cur.ready = 1'b1;
      end else begin
        next_cur.recov_cnt = cur.recov_cnt - 1'b1;
      end
    end
    // Conversion results land only while converting, so held results stay stable.
    if (result_valid && cur.conv) begin
      next_cur.res2 = ch2_button_result;
      next_cur.res3 = ch3_button_result;
    end
    if (reg_rd) begin
      next_cur.rvalid = 1'b1;
      case (reg_addr)
        OFS_CH2_LOW:    next_cur.rdata = cur.res2[7:0];
        OFS_CH2_HIGH:   next_cur.rdata = {4'h0, cur.res2[11:8]} & MASK_RESULT_HIGH;
        OFS_CH3_LOW:    next_cur.rdata = cur.res3[7:0];
        OFS_CH3_HIGH:   next_cur.rdata = {4'h0, cur.res3[11:8]} & MASK_RESULT_HIGH;
        OFS_RESET_CTRL: next_cur.rdata = {7'h00, cur.hold} & MASK_RESET_CTRL;
        OFS_CH_ENABLE:  next_cur.rdata = cur.ch_enable;
        OFS_SCAN_RATE:  next_cur.rdata = {4'h0, cur.scan_cfg} & MASK_SCAN_RATE;
        default:        next_cur.rdata = 8'h00;
      endcase
    end
    // Writes during reset recovery are dropped; the host must wait for chip ready first.
    if (reg_wr && cur.ready) begin
      case (reg_addr)
        OFS_RESET_CTRL: begin
          if (reg_wdata[BIT_FULL_RESET]) begin
            next_cur = ITCR_RESET;
          end else begin
            next_cur.hold = reg_wdata[BIT_CONFIG_HOLD];
          end
        end
        OFS_CH_ENABLE:  next_cur.ch_enable = reg_wdata;
        OFS_SCAN_RATE:  next_cur.scan_cfg = reg_wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Scan timing runs from the registered configuration to keep the long counter off the bus path.
  always_comb begin
    run_ok  = next_cur.ready && !next_cur.hold;
    cont_ok = cur.scan_cfg[BIT_CONT_SCAN] && !lowpower_mode;
    period  = itcr_period(cur.scan_cfg);
  end

  itcr_state_t scan_next;

  always_comb begin
    scan_next = next_cur;
    scan_next.conv = run_ok;
    scan_next.cont = run_ok && cont_ok;
    if (lowpower_mode) begin
      scan_next.active = cur.ch_enable[3:0] & cur.ch_enable[7:4];
    end else begin
      scan_next.active = cur.ch_enable[3:0];
    end
    if (!run_ok) begin
      scan_next.scan_cnt = '0;
      scan_next.tick = 1'b0;
      scan_next.active = 4'h0;
    end else if (lowpower_mode) begin
      scan_next.scan_cnt = '0;
      scan_next.tick = lp_scan_tick;
    end else if (cont_ok) begin
      scan_next.scan_cnt = '0;
      scan_next.tick = 1'b1;
    end else if (cur.scan_cnt >= period - 1'b1) begin
      scan_next.scan_cnt = '0;
      scan_next.tick = 1'b1;
    end else begin
      scan_next.scan_cnt = cur.scan_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cur <= ITCR_RESET;
    end else begin
      cur <= scan_next;
    end
  end

  always_comb begin
    reg_rdata            = cur.rdata;
    reg_rvalid           = cur.rvalid;
    chip_ready           = cur.ready;
    conv_enable          = cur.conv;
    active_channels      = cur.active;
    scan_tick            = cur.tick;
    continuous_active    = cur.cont;
    fixed_base_increment = cur.cont;
  end

  chk_low_result: assert property (@(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == OFS_CH2_LOW && !(reg_wr && reg_addr == OFS_RESET_CTRL))
      |=> reg_rvalid && reg_rdata == cur.res2[7:0] || reg_rdata == $past(cur.res2[7:0]))
    else $error("Channel 2 low result readback wrong.");

  chk_high_nibble: assert property (@(posedge mclk) disable iff (srst)
    (reg_rd && (reg_addr == OFS_CH2_HIGH || reg_addr == OFS_CH3_HIGH)) |=> reg_rdata[7:4] == 4'h0)
    else $error("High result upper nibble not zero.");

  chk_full_reset: assert property (@(posedge mclk) disable iff (srst)
    (reg_wr && chip_ready && reg_addr == OFS_RESET_CTRL && reg_wdata[BIT_FULL_RESET])
      |=> !chip_ready && cur.ch_enable == RST_CH_ENABLE && cur.scan_cfg == RST_SCAN_RATE && !cur.hold)
    else $error("Full reset did not restore defaults.");

  chk_ready_gate: assert property (@(posedge mclk) disable iff (srst)
    !chip_ready |-> !conv_enable && !scan_tick && active_channels == 4'h0)
    else $error("Activity before chip ready.");

  chk_hold_stop: assert property (@(posedge mclk) disable iff (srst)
    // A capture may still land on the very edge at which hold rises, so stability is only owed from the next one.
    (cur.hold && $past(cur.hold)) |-> !conv_enable && !scan_tick && $stable(cur.res2))
    else $error("Conversion activity during configuration hold.");

  chk_enable_mask: assert property (@(posedge mclk) disable iff (srst)
    (conv_enable && !$past(lowpower_mode)) |-> active_channels == $past(cur.ch_enable[3:0]))
    else $error("Active channels do not follow enables.");

  chk_lp_mask: assert property (@(posedge mclk) disable iff (srst)
    (conv_enable && $past(lowpower_mode)) |-> (active_channels & ~$past(cur.ch_enable[3:0])) == 4'h0)
    else $error("Low-power channel active without its enable.");

  chk_cont_back: assert property (@(posedge mclk) disable iff (srst)
    continuous_active |-> scan_tick)
    else $error("Continuous scan left a gap.");

  chk_cont_lowpwr: assert property (@(posedge mclk) disable iff (srst)
    $past(lowpower_mode) |-> !continuous_active)
    else $error("Continuous scan active in low power.");

  chk_scan_bound: assert property (@(posedge mclk) disable iff (srst)
    cur.scan_cnt < (cur.scan_cfg[BIT_FAST_SCAN] ? SCAN_CNT_W'(FAST_PERIOD) : SCAN_CNT_W'(FAST_PERIOD) << 4))
    else $error("Scan counter beyond period.");

  chk_reserved_rd: assert property (@(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == OFS_SCAN_RATE) |=> reg_rdata[7:4] == 4'h0)
    else $error("Reserved scan-rate bits read nonzero.");

  // Channel 3 uses the same byte split as channel 2.
  chk_low_ch3: assert property (@(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == OFS_CH3_LOW && !reg_wr) |=> reg_rvalid && reg_rdata == $past(cur.res3[7:0]))
    else $error("Channel 3 low result readback wrong.");

  chk_high_ch2: assert property (@(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == OFS_CH2_HIGH && !reg_wr) |=> reg_rdata[3:0] == $past(cur.res2[11:8]))
    else $error("Channel 2 high result readback wrong.");

  // Every read strobe is answered exactly one cycle later unless a full reset is written in the same cycle, and nothing else raises the answer.
  chk_rvalid_pulse: assert property (@(posedge mclk) disable iff (srst)
    reg_rd |=> reg_rvalid)
    else $error("Read strobe not answered.");

  chk_rvalid_only: assert property (@(posedge mclk) disable iff (srst)
    !reg_rd |=> !reg_rvalid)
    else $error("Read answer without a strobe.");

  // The full reset bit self-clears, so the control byte can only ever show the hold bit.
  chk_reset_rdbits: assert property (@(posedge mclk) disable iff (srst)
    (reg_rd && reg_addr == OFS_RESET_CTRL) |=> reg_rdata[7:1] == 7'h00)
    else $error("Reserved reset-control bits read nonzero.");

  // Once ready, only a full reset may take readiness away again.
  chk_ready_keep: assert property (@(posedge mclk) disable iff (srst)
    (chip_ready && !(reg_wr && reg_addr == OFS_RESET_CTRL && reg_wdata[BIT_FULL_RESET])) |=> chip_ready)
    else $error("Chip ready dropped without a full reset.");

  // Writes during recovery are dropped; the host has to poll for ready first.
  chk_write_gate: assert property (@(posedge mclk) disable iff (srst)
    (!chip_ready && reg_wr && reg_addr == OFS_CH_ENABLE) |=> $stable(cur.ch_enable))
    else $error("Enable register written before chip ready.");

  chk_conv_follow: assert property (@(posedge mclk) disable iff (srst)
    conv_enable == (chip_ready && !cur.hold))
    else $error("Conversion enable disagrees with ready and hold.");

  chk_enable_write: assert property (@(posedge mclk) disable iff (srst)
    (reg_wr && chip_ready && reg_addr == OFS_CH_ENABLE) |=> cur.ch_enable == $past(reg_wdata))
    else $error("Enable register write lost.");

  // Only the low nibble of the rate byte is stored; the rest is dropped on write.
  chk_rate_write: assert property (@(posedge mclk) disable iff (srst)
    (reg_wr && chip_ready && reg_addr == OFS_SCAN_RATE) |=> cur.scan_cfg == $past(reg_wdata[3:0]))
    else $error("Scan-rate register write lost.");

  // In low power the external timer paces scans, one cycle late, whatever the rate byte says.
  chk_lp_tick: assert property (@(posedge mclk) disable iff (srst)
    (conv_enable && lowpower_mode && lp_scan_tick && !reg_wr) |=> scan_tick)
    else $error("Low-power tick not passed on.");

  chk_fixed_inc: assert property (@(posedge mclk) disable iff (srst)
    fixed_base_increment == continuous_active)
    else $error("Fixed base increment disagrees with continuous scan.");

endmodule : itcr_regs

`default_nettype wire

// [tb/itcr_host.sv]
// Purpose: Host model driving the register strobe port of the bank.
// Assumes: One strobe per access, changed just after mclk rises.
// Notes:   Tasks are called hierarchically from the testbench.
`timescale 1ns/1ps
`default_nettype none
module itcr_host (
  input  wire logic       mclk,
  input  wire logic       chip_ready,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
  // Configuration goes in under hold so no scan sees a half-written setup.
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    wr(8'h0A, 8'h01);
    wr(a, d);
    wr(8'h0A, 8'h00);
  endtask : cfg
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      @(posedge mclk);
      ok = (chip_ready === 1'b1);
    end
  endtask : wait_ready
endmodule : itcr_host
`default_nettype wire

// [tb/inductive_touch_channel_config_regs_test.sv]
// Purpose: Self-checking bench for the result and configuration register bank.
// Assumes: Scan base period shortened to 16 cycles.
// Notes:   Register values are mirrored in a byte array and compared at every read.
`timescale 1ns/1ps
`default_nettype none
module inductive_touch_channel_config_regs_test;
  import itcr_pkg::*;
  localparam int FP = 16;
  logic        mclk, srst, result_valid, lowpower_mode, lp_scan_tick, ok;
  logic [11:0] ch2_button_result, ch3_button_result;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, e, mdl [16];
  logic        reg_wr, reg_rd, reg_rvalid, chip_ready, conv_enable;
  logic        scan_tick, continuous_active, fixed_base_increment;
  logic [3:0]  active_channels;
  int          err_total, n_compared, seed, n;
  itcr_regs #(.FAST_PERIOD(FP)) dut_u (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .ch2_button_result, .ch3_button_result, .result_valid, .lowpower_mode, .lp_scan_tick,
    .chip_ready, .conv_enable, .active_channels, .scan_tick, .continuous_active, .fixed_base_increment);
  itcr_host host_u (.mclk, .chip_ready, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input int a);
    logic [7:0] d;
    host_u.rd(a[7:0], d);
    chk("rdata", d, mdl[a]);
  endtask : rdchk
  task automatic mdl_reset;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[12] = 8'h1F;
    mdl[13] = 8'h01;
  endtask : mdl_reset
  // Syncs on one tick, then counts a whole interval to the next.
  task automatic gap(output int k);
    repeat (2) begin
      k = 0;
      do begin
        @(posedge mclk);
        #1;
        k++;
      end while (scan_tick !== 1'b1 && k < 300);
    end
  endtask : gap
  task automatic capture;
    ch2_button_result <= 12'($random(seed));
    ch3_button_result <= 12'($random(seed));
    result_valid <= 1'b1;
    @(posedge mclk);
    result_valid <= 1'b0;
  endtask : capture
  task automatic complete_run;
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    seed = 98;
    srst = 1'b1;
    {result_valid, lowpower_mode, lp_scan_tick, ch2_button_result, ch3_button_result} = '0;
    mdl_reset();
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    for (int a = 6; a < 15; a++) rdchk(a);
    host_u.wait_ready(ok);
    chk("ready", ok, 1);
    repeat (3) begin
      capture();
      mdl[6] = ch2_button_result[7:0];
      mdl[7] = {4'h0, ch2_button_result[11:8]};
      mdl[8] = ch3_button_result[7:0];
      mdl[9] = {4'h0, ch3_button_result[11:8]};
      for (int a = 6; a < 10; a++) rdchk(a);
    end
    host_u.wr(8'h0A, 8'hEF);
    mdl[10] = 8'h01;
    capture();
    gap(n);
    chk("conv", conv_enable, 0);
    chk("tick", n, 300);
    for (int a = 6; a < 11; a++) rdchk(a);
    host_u.wr(8'h0D, 8'hF2);
    mdl[13] = 8'h02;
    host_u.wr(8'h0A, 8'h00);
    mdl[10] = 8'h00;
    rdchk(13);
    repeat (4) begin
      e = 8'($random(seed));
      e[3:0] = e[3:0] | e[7:4];
      host_u.cfg(8'h0C, e);
      mdl[12] = e;
      rdchk(12);
      for (int lp = 0; lp < 2; lp++) begin
        lowpower_mode <= lp[0];
        repeat (3) @(posedge mclk);
        chk("chans", active_channels, lp ? e[3:0] & e[7:4] : e[3:0]);
      end
    end
    host_u.cfg(8'h0D, 8'h04);
    lp_scan_tick <= 1'b1;
    @(posedge mclk);
    lp_scan_tick <= 1'b0;
    #1;
    chk("lptick", scan_tick, 1);
    @(posedge mclk);
    #1;
    chk("lpcont", {scan_tick, continuous_active}, 0);
    lowpower_mode <= 1'b0;
    for (int c = 0; c < 12; c++) begin
      host_u.wr(8'h0D, 8'(c));
      gap(n);
      chk("gap", n, c > 7 ? FP : c > 3 ? 1 : FP << (c + 1));
      chk("fixinc", {continuous_active, fixed_base_increment}, (c > 3 && c < 8) ? 3 : 0);
    end
    host_u.wr(8'h0A, 8'h10);
    mdl_reset();
    repeat (2) @(posedge mclk);
    chk("rstready", chip_ready, 0);
    host_u.wr(8'h0C, 8'h00);
    for (int a = 6; a < 14; a++) rdchk(a);
    host_u.wait_ready(ok);
    chk("ready2", ok, 1);
    complete_run();
  end
endmodule : inductive_touch_channel_config_regs_test
`default_nettype wire
